// File: stepper_ctrl_pkg.sv
package stepper_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LOW_SPEED_OFS = 8'h04;
  localparam logic [7:0] HIGH_SPEED_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] POSITION_OFS = 8'h10;

  // Field positions
  localparam int CTRL_DIR_BIT = 0;
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_ENABLED_BIT = 2;
  localparam int STATUS_MOTION_BIT = 3;
  localparam int STATUS_DIR_BIT = 4;
  localparam int STATUS_SPEED_HIGH_BIT = 5;
  localparam int STATUS_PLUS_LIMIT_BIT = 6;
  localparam int STATUS_MINUS_LIMIT_BIT = 7;
  localparam int STATUS_SETUP_VIOL_BIT = 8;

  // Reset values
  localparam logic CTRL_DIR_RESET = 1'b0;
  localparam logic [15:0] LOW_SPEED_RESET = 16'h0100;
  localparam logic [15:0] HIGH_SPEED_RESET = 16'h1000;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int DIR_SETUP_NS = 5000;
  localparam int DIR_SETUP_CYCLES = (DIR_SETUP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    MODE_PULSE_DIR = 2'b00,
    MODE_LOW_HIGH = 2'b01,
    MODE_ANALOG = 2'b10,
    MODE_EXT_POT = 2'b11
  } drive_mode_t;

endpackage

// File: step_input_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module step_input_monitor
  import stepper_ctrl_pkg::*;
#(
  parameter int SETUP_CYCLES = DIR_SETUP_CYCLES,
  parameter int CNT_W = 12
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_active,
  input wire logic i_step,
  input wire logic i_dir,
  input wire logic i_clear_violation,
  output logic o_step_rise,
  output logic o_setup_violation
);

  if (SETUP_CYCLES < 1 || SETUP_CYCLES >= (1 << CNT_W)) begin : g_bad_setup
    $error("SETUP_CYCLES does not fit CNT_W");
  end

  typedef struct packed {
    logic step_prev;
    logic dir_prev;
    logic [CNT_W-1:0] since_dir;
    logic violation;
    logic primed;
  } mon_state_t;

  mon_state_t state;
  mon_state_t next_state;

  assign o_step_rise = i_step & ~state.step_prev;
  assign o_setup_violation = state.violation;

  always_comb begin
    logic dir_moved;
    dir_moved = 1'b0;
    next_state = state;
    next_state.primed = 1'b1;
    next_state.step_prev = i_step;
    next_state.dir_prev = i_dir;
    // The first sample after reset has no history, so it is not a direction change
    dir_moved = state.primed && (i_dir != state.dir_prev);
    if (dir_moved) begin
      next_state.since_dir = '0;
    end else if (state.since_dir != CNT_W'(SETUP_CYCLES)) begin
      next_state.since_dir = state.since_dir + CNT_W'(1);
    end
    if (i_clear_violation) begin
      next_state.violation = 1'b0;
    end
    // Set beats clear so a violation in the clearing cycle is kept
    if (i_active && o_step_rise &&
        (dir_moved || state.since_dir < CNT_W'(SETUP_CYCLES))) begin
      next_state.violation = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= '0;
      // Direction counts as long settled, so an early step is not flagged
      state.since_dir <= CNT_W'(SETUP_CYCLES);
    end else begin
      state <= next_state;
    end
  end

endmodule // step_input_monitor
`default_nettype wire

// File: stepper_drive_control_inputs.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module stepper_drive_control_inputs
  import stepper_ctrl_pkg::*;
#(
  parameter int SPEED_W = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_step_pulse_in,
  input wire logic i_dir_limit_in,
  input wire logic i_speed_limit_in,
  input wire logic i_drive_disable_in,
  input wire logic i_mode_switch_a,
  input wire logic i_mode_switch_b,
  output logic o_drive_enable,
  output logic o_motion_allowed,
  output logic o_step,
  output logic o_dir,
  output logic o_speed_high,
  output logic [SPEED_W-1:0] o_speed_setpoint
);

  // Refused at elaboration, so a bad width never reaches synthesis
  if (SPEED_W < 1 || SPEED_W > 16) begin : g_bad_speed_width
    $error("SPEED_W must be 1 to 16");
  end

  // All state of the block except the step monitor's, registers and outputs alike, lives in one struct
  typedef struct packed {
    logic ctrl_dir;
    logic [SPEED_W-1:0] low_speed;
    logic [SPEED_W-1:0] high_speed;
    logic [31:0] position;
    logic [31:0] prdata;
    logic pslverr;
    logic enable;
    logic motion;
    logic step;
    logic dir;
    logic speed_high;
    logic plus_limit;
    logic minus_limit;
    logic [SPEED_W-1:0] setpoint;
  } drive_state_t;

  drive_state_t state;
  drive_state_t next_state;

  drive_mode_t mode;
  logic step_rise;
  logic setup_violation;
  logic clear_violation;
  logic apb_access;
  logic apb_write;

  // Switches are read live; moving them during motion is left to the user
  assign mode = drive_mode_t'({i_mode_switch_b, i_mode_switch_a});
  assign apb_access = i_psel & i_penable;
  assign apb_write = apb_access & i_pwrite;
  assign clear_violation = apb_write && i_paddr == STATUS_OFS && i_pwdata[STATUS_SETUP_VIOL_BIT];

  // Edge detection and the direction setup watch sit in their own module
  step_input_monitor #(
    .SETUP_CYCLES(DIR_SETUP_CYCLES),
    .CNT_W(12)
  ) u_monitor (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_active(mode == MODE_PULSE_DIR),
    .i_step(i_step_pulse_in),
    .i_dir(i_dir_limit_in),
    .i_clear_violation(clear_violation),
    .o_step_rise(step_rise),
    .o_setup_violation(setup_violation)
  );

  always_comb begin
    logic enabled;
    logic run;
    logic dir;
    logic plus_lim;
    logic minus_lim;
    logic speed_high;
    logic blocked;
    enabled = 1'b0;
    run = 1'b0;
    dir = 1'b0;
    plus_lim = 1'b0;
    minus_lim = 1'b0;
    speed_high = 1'b0;
    blocked = 1'b0;
    next_state = state;
    next_state.step = 1'b0;

    enabled = i_drive_disable_in;
    // Pulse, low/high and the two analog modes give the shared inputs three different meanings
    case (mode)
      MODE_PULSE_DIR: begin
        // No limits here: the second input carries direction
        dir = i_dir_limit_in;
        run = 1'b1;
        speed_high = 1'b0;
      end
      MODE_LOW_HIGH: begin
        // Speed select: low picks the low setpoint, open picks the high one
        run = ~i_step_pulse_in;
        dir = i_dir_limit_in;
        speed_high = i_speed_limit_in;
      end
      MODE_ANALOG, MODE_EXT_POT: begin
        // No pin carries direction here, so software sets it
        run = ~i_step_pulse_in;
        dir = state.ctrl_dir;
        plus_lim = ~i_dir_limit_in;
        minus_lim = ~i_speed_limit_in;
        speed_high = 1'b1;
      end
      default: begin
        // Unreachable with a two-bit switch pair, kept as a safe stop
        run = 1'b0;
      end
    endcase

    // Travel toward a tripped limit is refused; the opposite way stays free
    blocked = dir ? plus_lim : minus_lim;
    next_state.enable = enabled;
    next_state.motion = enabled & run & ~blocked;
    next_state.dir = dir;
    next_state.speed_high = speed_high;
    next_state.plus_limit = plus_lim;
    next_state.minus_limit = minus_lim;
    next_state.setpoint = speed_high ? state.high_speed : state.low_speed;

    // A step that breaks the setup time is still taken; only the sticky flag records it
    // Position wraps silently at 32 bits
    if (mode == MODE_PULSE_DIR && enabled && step_rise) begin
      next_state.step = 1'b1;
      next_state.position = dir ? state.position + 32'h00000001
                                : state.position - 32'h00000001;
    end

    // Zero-wait slave: every access completes in its first access cycle
    next_state.pslverr = 1'b0;
    if (i_psel && !i_penable) begin
      next_state.prdata = 32'h00000000;
      next_state.pslverr = 1'b0;
      case (i_paddr)
        CTRL_OFS: next_state.prdata[CTRL_DIR_BIT] = state.ctrl_dir;
        LOW_SPEED_OFS: next_state.prdata[SPEED_W-1:0] = state.low_speed;
        HIGH_SPEED_OFS: next_state.prdata[SPEED_W-1:0] = state.high_speed;
        STATUS_OFS: begin
          next_state.prdata[STATUS_MODE_LSB +: 2] = mode;
          next_state.prdata[STATUS_ENABLED_BIT] = state.enable;
          next_state.prdata[STATUS_MOTION_BIT] = state.motion;
          next_state.prdata[STATUS_DIR_BIT] = state.dir;
          next_state.prdata[STATUS_SPEED_HIGH_BIT] = state.speed_high;
          next_state.prdata[STATUS_PLUS_LIMIT_BIT] = state.plus_limit;
          next_state.prdata[STATUS_MINUS_LIMIT_BIT] = state.minus_limit;
          next_state.prdata[STATUS_SETUP_VIOL_BIT] = setup_violation;
        end
        POSITION_OFS: next_state.prdata = state.position;
        default: next_state.pslverr = 1'b1;
      endcase
    end else if (apb_access) begin
      next_state.pslverr = state.pslverr;
    end
    // Writes commit at the access-phase edge; unmapped ones are dropped
    if (apb_write) begin
      case (i_paddr)
        CTRL_OFS: next_state.ctrl_dir = i_pwdata[CTRL_DIR_BIT];
        LOW_SPEED_OFS: next_state.low_speed = i_pwdata[SPEED_W-1:0];
        HIGH_SPEED_OFS: next_state.high_speed = i_pwdata[SPEED_W-1:0];
        default: next_state.ctrl_dir = state.ctrl_dir;
      endcase
    end
  end

  // Setpoints reset to their defaults, everything else to zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= '0;
      state.ctrl_dir <= CTRL_DIR_RESET;
      state.low_speed <= LOW_SPEED_RESET[SPEED_W-1:0];
      state.high_speed <= HIGH_SPEED_RESET[SPEED_W-1:0];
    end else begin
      state <= next_state;
    end
  end

  // Zero wait states, so ready is a constant high
  assign o_pready = 1'b1;
  assign o_prdata = state.prdata;
  assign o_pslverr = apb_access & state.pslverr;
  assign o_drive_enable = state.enable;
  assign o_motion_allowed = state.motion;
  assign o_step = state.step;
  assign o_dir = state.dir;
  assign o_speed_high = state.speed_high;
  assign o_speed_setpoint = state.setpoint;

endmodule // stepper_drive_control_inputs
`default_nettype wire

// File: stepper_drive_control_inputs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sdci_checker (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_step_pulse_in,
  input wire logic i_dir_limit_in,
  input wire logic i_speed_limit_in,
  input wire logic i_drive_disable_in,
  input wire logic i_mode_switch_a,
  input wire logic i_mode_switch_b,
  input wire logic o_drive_enable,
  input wire logic o_motion_allowed,
  input wire logic o_step,
  input wire logic o_dir,
  input wire logic o_speed_high
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic [1:0] mode;
  assign mode = {i_mode_switch_b, i_mode_switch_a};
  // Enable is taken from the registered copy too, so a same-edge enable is not judged
  sequence rise_enabled;
    $rose(i_step_pulse_in) && mode == 2'b00 && i_drive_disable_in && o_drive_enable;
  endsequence
  a_step_one_pulse: assert property (rise_enabled |=> o_step ##1 !o_step)
    else $error("step pulse missing or too long");
  a_mode_no_step: assert property (mode != 2'b00 |=> !o_step)
    else $error("step issued outside pulse mode");
  a_run_halt: assert property (mode != 2'b00 && i_step_pulse_in |=> !o_motion_allowed)
    else $error("motion while stopped");
  a_run_go: assert property (
    mode == 2'b01 && !i_step_pulse_in && i_drive_disable_in |=> o_motion_allowed)
    else $error("no motion while running");
  a_plus_block: assert property (
    mode[1] && !i_dir_limit_in |=> !(o_motion_allowed && o_dir))
    else $error("positive travel past limit");
  a_minus_block: assert property (
    mode[1] && !i_speed_limit_in |=> !(o_motion_allowed && !o_dir))
    else $error("negative travel past limit");
  a_speed_low: assert property (mode == 2'b01 && !i_speed_limit_in |=> !o_speed_high)
    else $error("high speed while low selected");
  a_speed_high: assert property (mode == 2'b01 && i_speed_limit_in |=> o_speed_high)
    else $error("low speed while high selected");
  a_disable_all: assert property (
    !i_drive_disable_in |=> !o_drive_enable && !o_motion_allowed && !o_step)
    else $error("motion while disabled");
endmodule // sdci_checker
bind stepper_drive_control_inputs sdci_checker u_chk (.i_clk, .i_srst, .i_step_pulse_in,
  .i_dir_limit_in, .i_speed_limit_in, .i_drive_disable_in, .i_mode_switch_a, .i_mode_switch_b,
  .o_drive_enable, .o_motion_allowed, .o_step, .o_dir, .o_speed_high);
`default_nettype wire

// File: step_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module step_ctrl_model #(
  parameter int SETUP = 1250
) (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_dir,
  input wire logic i_lvl,
  output logic o_step,
  output logic o_dir,
  output logic o_busy
);
  int cnt = 0;
  assign o_busy = (cnt != 0) || i_go;
  // Direction moves first; the step edge comes SETUP+2 cycles later
  always @(posedge i_clk) begin
    if (i_go) begin
      o_dir <= i_dir;
      cnt <= SETUP + 4;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      o_step <= (cnt == 3) || (cnt == 2);
    end else begin
      o_step <= i_lvl;
      o_dir <= i_dir;
    end
  end
endmodule // step_ctrl_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import stepper_ctrl_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic go = 0, dir = 1, lvl = 0, speed = 1, ena = 1, ma = 0, mb = 0;
  logic pready, pslverr, drive_en, motion, stp, odir, spd_hi;
  logic [15:0] setpoint;
  wire step_line, dir_line, busy;
  int num_errors = 0, checked = 0, cycles = 0, steps = 0;
  always #2 clk = ~clk;
  step_ctrl_model #(.SETUP(DIR_SETUP_CYCLES)) u_ctrl (.i_clk(clk), .i_go(go), .i_dir(dir),
    .i_lvl(lvl), .o_step(step_line), .o_dir(dir_line), .o_busy(busy));
  stepper_drive_control_inputs u_dut (.i_clk(clk), .i_srst(srst), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_step_pulse_in(step_line),
    .i_dir_limit_in(dir_line), .i_speed_limit_in(speed), .i_drive_disable_in(ena),
    .i_mode_switch_a(ma), .i_mode_switch_b(mb), .o_drive_enable(drive_en),
    .o_motion_allowed(motion), .o_step(stp), .o_dir(odir), .o_speed_high(spd_hi),
    .o_speed_setpoint(setpoint));
  task final_report;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (stp === 1'b1) steps++;
    if (cycles == 30000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic step_once(input logic d);
    @(posedge clk);
    dir <= d;
    go <= 1;
    @(posedge clk);
    go <= 0;
    for (int i = 0; i < 2000 && busy; i++) @(posedge clk);
    chk(busy, 1'b0);
  endtask
  initial begin
    tick(5);
    srst <= 0;
    apb(0, HIGH_SPEED_OFS, 0);
    chk(rdata, {16'h0000, HIGH_SPEED_RESET});
    apb(0, 8'h40, 0);
    chk({rdata[30:0], perr}, 32'h1);
    apb(1, LOW_SPEED_OFS, 32'h0123);
    // Pulse mode: +3 then -2 must leave one step net
    for (int i = 0; i < 5; i++) step_once(i < 3);
    chk(steps, 32'h5);
    apb(0, POSITION_OFS, 0);
    chk(rdata, 32'h1);
    apb(0, STATUS_OFS, 0);
    chk(rdata[STATUS_SETUP_VIOL_BIT], 1'b0);
    ena <= 0;
    step_once(1);
    chk(steps, 32'h5);
    // Direction and step move together: the sticky flag must catch it, then clear
    dir <= 0;
    lvl <= 1;
    tick(3);
    lvl <= 0;
    apb(0, STATUS_OFS, 0);
    chk(rdata[STATUS_SETUP_VIOL_BIT], 1'b1);
    apb(1, STATUS_OFS, 32'h100);
    apb(0, STATUS_OFS, 0);
    chk(rdata[STATUS_SETUP_VIOL_BIT], 1'b0);
    ena <= 1;
    ma <= 1;
    speed <= 0;
    tick(3);
    chk({spd_hi, setpoint, motion}, {1'b0, 16'h0123, 1'b1});
    speed <= 1;
    lvl <= 1;
    tick(3);
    chk({spd_hi, setpoint, motion}, {1'b1, HIGH_SPEED_RESET, 1'b0});
    lvl <= 0;
    for (int m = 2; m < 4; m++) begin
      {mb, ma} <= m[1:0];
      apb(1, CTRL_OFS, 32'h1);
      dir <= 0;
      tick(3);
      chk(motion, 1'b0);
      dir <= 1;
      tick(3);
      chk({odir, motion}, 2'b11);
      apb(1, CTRL_OFS, 32'h0);
      speed <= 0;
      tick(3);
      chk(motion, 1'b0);
      speed <= 1;
      tick(3);
      chk({odir, motion}, 2'b01);
    end
    ena <= 0;
    tick(3);
    chk({drive_en, motion}, 2'b00);
    final_report();
  end
endmodule // testbench
`default_nettype wire
